// >>> dbtc_pkg.sv
package dbtc_pkg;
  localparam int AW = 12;
  localparam logic [7:0] OFF_TIMING = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [15:0] TIMING_RESET = 16'h051F;
  localparam logic [15:0] TIMING_WMASK = 16'hFF5F;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [7:0] CONFIG_WMASK = 8'hF8;
  // Segment lengths in half clocks
  localparam logic [2:0] HALF_0P5 = 3'h1;
  localparam logic [2:0] HALF_1P5 = 3'h3;
  localparam logic [2:0] HALF_2P5 = 3'h5;
  localparam logic [2:0] HALF_1CLK = 3'h2;
  localparam logic [2:0] HALF_2CLK = 3'h4;
  localparam logic [2:0] HALF_NONE = 3'h0;
  localparam logic [1:0] COL_STROBE_WIDTH_LONG = 2'h2;
  localparam logic [4:0] ACK_LAST = 5'h1F;
  localparam logic [2:0] BEAT_ONE = 3'h0;
  localparam logic [2:0] BEAT_TWO = 3'h1;
  localparam logic [2:0] BEAT_FOUR = 3'h3;
  localparam logic [2:0] BEAT_EIGHT = 3'h7;
  localparam logic [1:0] WORD_LAST = 2'h3;

  typedef enum logic [1:0] {
    PW_32 = 2'b00, PW_RSVD = 2'b01, PW_16 = 2'b10, PW_64 = 2'b11
  } dbtc_pw_e;
  typedef enum logic [2:0] {
    XC_LATCH = 3'b000, XC_PLAIN = 3'b001, XC_MUX = 3'b010
  } dbtc_xcvr_e;
  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000, SQ_PRE = 3'b001, SQ_RSET = 3'b010, SQ_RHOLD = 3'b011,
    SQ_CSET = 3'b100, SQ_CACT = 3'b101, SQ_TURN = 3'b110
  } dbtc_seq_e;

  typedef struct packed {
    logic [1:0] pre;
    logic row_hold;
    logic setup;
    logic [1:0] col_strobe_width;
    logic [1:0] rdta;
    logic zero7;
    logic wrta;
    logic zero5;
    logic [4:0] ack;
  } dbtc_timing_s;
  typedef struct packed {
    logic [2:0] xcvr;
    logic [1:0] pw;
    logic [2:0] zero;
  } dbtc_cfg_s;
  typedef struct packed {
    dbtc_seq_e st;
    logic [2:0] cnt;
    logic [2:0] beat;
  } dbtc_seq_s;
  typedef struct packed {
    logic [3:0] ras_n;
    logic [3:0] cas_n;
    logic col;
    logic drive;
    logic rd_even;
    logic rd_odd;
  } dbtc_pins_s;
  typedef struct packed {
    logic [1:0] bank;
    logic wr;
    logic burst;
    logic pair;
    logic ilv;
    logic half16;
    logic [2:0] last;
    logic [11:0] row;
    logic [11:0] col;
    dbtc_timing_s t;
    dbtc_cfg_s c;
  } dbtc_acc_s;
endpackage

// >>> dbtc_regs.sv
`timescale 1ns/10ps
module dbtc_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] status,
  output dbtc_pkg::dbtc_timing_s [3:0] timing,
  output dbtc_pkg::dbtc_cfg_s [3:0] cfg
);
  logic [15:0] tm [4];
  logic [7:0] cf [4];
  logic [15:0] next_tm [4];
  logic [7:0] next_cf [4];
  logic [31:0] next_prdata;
  logic next_pslverr;

  // {mapped, kind(0 timing,1 config,2 status), bank}
  function automatic logic [4:0] decode(input logic [7:0] a);
    decode = 5'h00;
    if (a[7:4] == dbtc_pkg::OFF_TIMING[7:4] && a[1:0] == 2'h0) begin
      decode = {1'b1, 2'h0, a[3:2]};
    end else if (a[7:4] == dbtc_pkg::OFF_CONFIG[7:4] && a[1:0] == 2'h0) begin
      decode = {1'b1, 2'h1, a[3:2]};
    end else if (a == dbtc_pkg::OFF_STATUS) begin
      decode = {1'b1, 2'h2, 2'h0};
    end
  endfunction

  assign pready = 1'b1;

  always_comb begin
    logic [4:0] d;
    d = decode(paddr);
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (psel && !penable) begin
      next_pslverr = !d[4];
      case (d[3:2])
        2'h0: next_prdata = {16'h0000, tm[d[1:0]]};
        2'h1: next_prdata = {24'h000000, cf[d[1:0]]};
        2'h2: next_prdata = {24'h000000, status};
        default: next_prdata = 32'h00000000;
      endcase
      if (!d[4]) begin
        next_prdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_bank
    always_comb begin
      logic [4:0] d;
      d = decode(paddr);
      next_tm[i] = tm[i];
      next_cf[i] = cf[i];
      if (psel && penable && pwrite && d[4] && d[1:0] == 2'(i)) begin
        if (d[3:2] == 2'h0) begin
          next_tm[i] = pwdata[15:0] & dbtc_pkg::TIMING_WMASK;
        end
        if (d[3:2] == 2'h1) begin
          next_cf[i] = pwdata[7:0] & dbtc_pkg::CONFIG_WMASK;
        end
      end
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tm[i] <= dbtc_pkg::TIMING_RESET;
        cf[i] <= dbtc_pkg::CONFIG_RESET;
      end else begin
        tm[i] <= next_tm[i];
        cf[i] <= next_cf[i];
      end
    end
    assign timing[i] = tm[i];
    assign cfg[i] = cf[i];
  end
endmodule

// >>> dbtc_oe_map.sv
`timescale 1ns/10ps
module dbtc_oe_map (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] xcvr,
  input wire logic rd_even,
  input wire logic rd_odd,
  output logic even_read_output_enable_n,
  output logic odd_read_output_enable_n
);
  logic next_even_n;
  logic next_odd_n;

  always_comb begin
    next_odd_n = !rd_odd;
    if (xcvr == dbtc_pkg::XC_MUX) begin
      next_even_n = !(rd_even || rd_odd);
    end else begin
      next_even_n = !rd_even;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      even_read_output_enable_n <= 1'b1;
      odd_read_output_enable_n <= 1'b1;
    end else begin
      even_read_output_enable_n <= next_even_n;
      odd_read_output_enable_n <= next_odd_n;
    end
  end
endmodule

// >>> dbtc_ctrl.sv
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/10ps
module dbtc_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic acc_valid,
  output logic acc_ready,
  input wire logic [1:0] acc_bank,
  input wire logic acc_write,
  input wire logic acc_burst,
  input wire logic acc_page_hit,
  input wire logic [11:0] acc_row,
  input wire logic [11:0] acc_col,
  output dbtc_pkg::dbtc_pins_s pins_h0,
  output dbtc_pkg::dbtc_pins_s pins_h1,
  output logic [11:0] dram_addr,
  output logic data_ready,
  output logic [1:0] data_word,
  output logic burst_ack,
  output logic bus_stall,
  output logic even_read_output_enable_n,
  output logic odd_read_output_enable_n
);
  dbtc_pkg::dbtc_timing_s [3:0] timing;
  dbtc_pkg::dbtc_cfg_s [3:0] cfg;
  dbtc_pkg::dbtc_acc_s cur;
  dbtc_pkg::dbtc_acc_s next_cur;
  dbtc_pkg::dbtc_acc_s a;
  dbtc_pkg::dbtc_seq_s seq;
  dbtc_pkg::dbtc_seq_s mid;
  dbtc_pkg::dbtc_seq_s next_seq;
  dbtc_pkg::dbtc_pins_s p0;
  dbtc_pkg::dbtc_pins_s p1;
  dbtc_pkg::dbtc_pins_s next_h0;
  dbtc_pkg::dbtc_pins_s next_h1;
  logic [7:0] status;
  logic accept;
  logic second;
  logic next_second;
  logic ack_on;
  logic next_ack_on;
  logic acked;
  logic next_acked;
  logic [4:0] ack_cnt;
  logic [4:0] next_ack_cnt;
  logic rd_end;
  logic cas_first;
  logic [2:0] end_beat;
  logic next_data_ready;
  logic [1:0] next_data_word;
  logic next_burst_ack;
  logic next_bus_stall;
  logic [11:0] next_dram_addr;
  logic oe_even;
  logic oe_odd;

  dbtc_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .status(status),
    .timing(timing),
    .cfg(cfg)
  );

  // Length of one sequencer segment in half clocks
  function automatic logic [2:0] seg_len(input dbtc_pkg::dbtc_seq_e st, input dbtc_pkg::dbtc_acc_s c);
    case (st)
      dbtc_pkg::SQ_PRE: seg_len = c.t.pre[0] ? dbtc_pkg::HALF_2CLK : dbtc_pkg::HALF_1CLK;
      dbtc_pkg::SQ_RSET: seg_len = c.t.setup ? dbtc_pkg::HALF_1P5 : dbtc_pkg::HALF_0P5;
      dbtc_pkg::SQ_RHOLD: seg_len = c.t.row_hold ? dbtc_pkg::HALF_1P5 : dbtc_pkg::HALF_0P5;
      dbtc_pkg::SQ_CSET: seg_len = c.t.setup ? dbtc_pkg::HALF_1P5 : dbtc_pkg::HALF_0P5;
      // Reserved widths fall back to the short pulse
      dbtc_pkg::SQ_CACT: seg_len = (c.t.col_strobe_width == dbtc_pkg::COL_STROBE_WIDTH_LONG) ? dbtc_pkg::HALF_2P5
                                                                    : dbtc_pkg::HALF_1P5;
      dbtc_pkg::SQ_TURN: seg_len = c.wr ? dbtc_pkg::HALF_NONE : {c.t.rdta, 1'b0};
      default: seg_len = dbtc_pkg::HALF_NONE;
    endcase
  endfunction

  function automatic dbtc_pkg::dbtc_seq_s enter(input dbtc_pkg::dbtc_seq_e st, input logic [2:0] beat,
                                                 input dbtc_pkg::dbtc_acc_s c);
    enter.st = st;
    enter.cnt = seg_len(st, c);
    enter.beat = beat;
    if (enter.cnt == dbtc_pkg::HALF_NONE) begin
      enter.st = dbtc_pkg::SQ_IDLE;
      enter.beat = 3'h0;
    end
  endfunction

  // Advance the sequencer by one half clock
  function automatic dbtc_pkg::dbtc_seq_s half_step(input dbtc_pkg::dbtc_seq_s s, input dbtc_pkg::dbtc_acc_s c);
    half_step = s;
    if (s.st != dbtc_pkg::SQ_IDLE) begin
      if (s.cnt > 3'h1) begin
        half_step.cnt = s.cnt - 3'h1;
      end else begin
        case (s.st)
          dbtc_pkg::SQ_PRE: half_step = enter(dbtc_pkg::SQ_RSET, s.beat, c);
          dbtc_pkg::SQ_RSET: half_step = enter(dbtc_pkg::SQ_RHOLD, s.beat, c);
          dbtc_pkg::SQ_RHOLD: half_step = enter(dbtc_pkg::SQ_CSET, s.beat, c);
          dbtc_pkg::SQ_CSET: half_step = enter(dbtc_pkg::SQ_CACT, s.beat, c);
          dbtc_pkg::SQ_CACT: begin
            if (s.beat == c.last) begin
              half_step = enter(dbtc_pkg::SQ_TURN, s.beat, c);
            end else begin
              half_step = enter(dbtc_pkg::SQ_CSET, s.beat + 3'h1, c);
            end
          end
          default: half_step = enter(dbtc_pkg::SQ_IDLE, 3'h0, c);
        endcase
      end
    end
  endfunction

  // Pin levels for one half clock
  function automatic dbtc_pkg::dbtc_pins_s pins_of(input dbtc_pkg::dbtc_seq_s s, input dbtc_pkg::dbtc_acc_s c);
    logic act;
    logic [3:0] mask;
    act = s.st == dbtc_pkg::SQ_RHOLD || s.st == dbtc_pkg::SQ_CSET || s.st == dbtc_pkg::SQ_CACT;
    if (c.ilv) begin
      mask = 4'h3 << {c.bank[1], 1'b0};
    end else begin
      mask = 4'h1 << c.bank;
    end
    pins_of.ras_n = act ? ~mask : 4'hF;
    pins_of.cas_n = (s.st == dbtc_pkg::SQ_CACT) ? ~mask : 4'hF;
    pins_of.col = s.st == dbtc_pkg::SQ_CSET || s.st == dbtc_pkg::SQ_CACT;
    pins_of.drive = c.wr && s.st != dbtc_pkg::SQ_IDLE && s.st != dbtc_pkg::SQ_TURN
                    && !(s.st == dbtc_pkg::SQ_CACT && s.beat == c.last && !c.t.wrta
                         && s.cnt <= dbtc_pkg::HALF_1CLK);
    pins_of.rd_even = !c.wr && act && (c.ilv || !c.bank[0]);
    pins_of.rd_odd = !c.wr && act && (c.ilv || c.bank[0]);
  endfunction

  assign acc_ready = seq.st == dbtc_pkg::SQ_IDLE;
  assign accept = acc_ready && acc_valid;
  assign status = {1'b0, !acc_ready, bus_stall, seq.st, cur.bank};

  // Access capture and sequencer
  always_comb begin
    a.bank = acc_bank;
    a.wr = acc_write;
    a.burst = acc_burst;
    a.row = acc_row;
    a.col = acc_col;
    // The pair partner is assumed to hold identical settings
    a.t = timing[acc_bank];
    a.c = cfg[acc_bank];
    a.half16 = a.c.pw == dbtc_pkg::PW_16;
    a.ilv = a.c.pw == dbtc_pkg::PW_64
            && (a.c.xcvr == dbtc_pkg::XC_MUX || a.c.xcvr == dbtc_pkg::XC_LATCH);
    a.pair = !acc_write && acc_burst && !a.half16 && a.c.xcvr != dbtc_pkg::XC_PLAIN;
    if (!acc_burst) begin
      a.last = a.half16 ? dbtc_pkg::BEAT_TWO : dbtc_pkg::BEAT_ONE;
    end else if (a.pair) begin
      a.last = dbtc_pkg::BEAT_TWO;
    end else begin
      a.last = a.half16 ? dbtc_pkg::BEAT_EIGHT : dbtc_pkg::BEAT_FOUR;
    end
    next_cur = cur;
    mid = half_step(seq, cur);
    next_seq = half_step(mid, cur);
    if (accept) begin
      next_cur = a;
      if (acc_page_hit) begin
        next_seq = enter(dbtc_pkg::SQ_CSET, 3'h0, a);
      end else begin
        next_seq = enter(dbtc_pkg::SQ_PRE, 3'h0, a);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      seq <= '{st: dbtc_pkg::SQ_IDLE, cnt: 3'h0, beat: 3'h0};
    end else begin
      cur <= next_cur;
      seq <= next_seq;
    end
  end

  // Pins, data return and acknowledge
  always_comb begin
    p0 = pins_of(seq, cur);
    p1 = pins_of(mid, cur);
    next_h0 = p0;
    next_h1 = p1;
    if (cur.pair) begin
      next_dram_addr = cur.col + {10'h000, mid.beat[0], 1'b0};
    end else begin
      next_dram_addr = cur.col + {9'h000, mid.beat};
    end
    if (!p1.col) begin
      next_dram_addr = cur.row;
    end
    rd_end = 1'b0;
    end_beat = mid.beat;
    if (seq.st == dbtc_pkg::SQ_CACT && seq.cnt == 3'h1) begin
      rd_end = !cur.wr;
      end_beat = seq.beat;
    end else if (mid.st == dbtc_pkg::SQ_CACT && mid.cnt == 3'h1) begin
      rd_end = !cur.wr;
    end
    if (cur.half16 && !end_beat[0]) begin
      rd_end = 1'b0;
    end
    next_data_ready = rd_end || second;
    next_second = rd_end && cur.pair;
    if (!rd_end) begin
      next_data_word = data_word + 2'h1;
    end else if (cur.pair) begin
      next_data_word = {end_beat[0], 1'b0};
    end else if (cur.half16) begin
      next_data_word = end_beat[2:1];
    end else begin
      next_data_word = end_beat[1:0];
    end
    if (!next_data_ready) begin
      next_data_word = data_word;
    end
    cas_first = (seq.st == dbtc_pkg::SQ_CACT || mid.st == dbtc_pkg::SQ_CACT) && seq.beat == 3'h0;
    next_ack_on = ack_on;
    next_ack_cnt = ack_cnt;
    next_acked = acked;
    if (accept) begin
      next_ack_on = 1'b0;
      next_ack_cnt = 5'h00;
      next_acked = 1'b0;
    end else if (ack_on) begin
      if (ack_cnt != dbtc_pkg::ACK_LAST) begin
        next_ack_cnt = ack_cnt + 5'h01;
      end
    end else if (cas_first) begin
      next_ack_on = 1'b1;
    end
    next_burst_ack = 1'b0;
    if (cur.burst && !cur.wr && !acked && seq.st != dbtc_pkg::SQ_IDLE) begin
      if (cur.t.ack == dbtc_pkg::ACK_LAST) begin
        next_burst_ack = next_data_ready && next_data_word == dbtc_pkg::WORD_LAST;
      end else begin
        next_burst_ack = ack_on && ack_cnt == cur.t.ack;
      end
    end
    if (next_burst_ack) begin
      next_acked = 1'b1;
    end
    next_bus_stall = next_seq.st == dbtc_pkg::SQ_TURN;
    oe_even = p1.rd_even && !(cur.ilv && second);
    oe_odd = p1.rd_odd && !(cur.ilv && !second);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_h0 <= '{ras_n: 4'hF, cas_n: 4'hF, col: 1'b0, drive: 1'b0, rd_even: 1'b0, rd_odd: 1'b0};
      pins_h1 <= '{ras_n: 4'hF, cas_n: 4'hF, col: 1'b0, drive: 1'b0, rd_even: 1'b0, rd_odd: 1'b0};
      dram_addr <= 12'h000;
      data_ready <= 1'b0;
      data_word <= 2'h0;
      second <= 1'b0;
      burst_ack <= 1'b0;
      ack_on <= 1'b0;
      ack_cnt <= 5'h00;
      acked <= 1'b0;
      bus_stall <= 1'b0;
    end else begin
      pins_h0 <= next_h0;
      pins_h1 <= next_h1;
      dram_addr <= next_dram_addr;
      data_ready <= next_data_ready;
      data_word <= next_data_word;
      second <= next_second;
      burst_ack <= next_burst_ack;
      ack_on <= next_ack_on;
      ack_cnt <= next_ack_cnt;
      acked <= next_acked;
      bus_stall <= next_bus_stall;
    end
  end

  dbtc_oe_map u_oe (
    .pclk(pclk),
    .presetn(presetn),
    .xcvr(cur.c.xcvr),
    .rd_even(oe_even),
    .rd_odd(oe_odd),
    .even_read_output_enable_n(even_read_output_enable_n),
    .odd_read_output_enable_n(odd_read_output_enable_n)
  );
endmodule

// >>> dbtc_ctrl_monitor.sv
`timescale 1ns/10ps
module dbtc_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic acc_valid,
  input wire logic acc_ready,
  input wire logic [1:0] acc_bank,
  input wire logic acc_page_hit,
  input wire dbtc_pkg::dbtc_pins_s pins_h0,
  input wire dbtc_pkg::dbtc_pins_s pins_h1,
  input wire logic data_ready,
  input wire logic [1:0] data_word,
  input wire logic burst_ack,
  input wire logic bus_stall
);
  dbtc_pkg::dbtc_timing_s t0;
  logic [2:0] rcnt;
  logic [2:0] rexp;
  logic [2:0] slen;
  logic take;
  logic ras_fall;
  assign take = acc_valid && acc_ready && !acc_page_hit && acc_bank == 2'h0;
  assign ras_fall = pins_h0.ras_n[0] && !pins_h1.ras_n[0];
  // Shadow of bank 0 timing and clocks from a page miss to the row strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0 <= dbtc_pkg::TIMING_RESET;
      rcnt <= 3'h0;
      rexp <= 3'h0;
      slen <= 3'h0;
    end else begin
      if (psel && penable && pwrite && paddr == dbtc_pkg::OFF_TIMING) begin
        t0 <= pwdata[15:0] & dbtc_pkg::TIMING_WMASK;
      end
      if (take) begin
        rcnt <= 3'h1;
        rexp <= 3'h3 + {2'h0, t0.pre[0]} + {2'h0, t0.setup};
      end else if (ras_fall) begin
        rcnt <= 3'h0;
      end else if (rcnt != 3'h0) begin
        rcnt <= rcnt + 3'h1;
      end
      slen <= bus_stall ? slen + 3'h1 : 3'h0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence ras_drop;
    pins_h0.ras_n[0] && !pins_h1.ras_n[0];
  endsequence
  sequence cas_drop_h1;
    pins_h0.cas_n[0] && !pins_h1.cas_n[0];
  endsequence
  timing_read_a: assert property (psel && penable && !pwrite && paddr == dbtc_pkg::OFF_TIMING
    |-> prdata == {16'h0, t0}) else $error("timing register readback differs");
  ras_delay_a: assert property (ras_fall && rcnt != 3'h0 |-> rcnt == rexp)
    else $error("row strobe asserted at wrong time");
  ras_bound_a: assert property (rcnt <= rexp) else $error("row strobe late after page miss");
  row_hold_a: assert property (ras_drop |-> ##1 (t0.row_hold ? !(pins_h0.col || pins_h1.col) : pins_h0.col)
    ##1 (!t0.row_hold || pins_h0.col)) else $error("row address hold wrong");
  col_hold_a: assert property (cas_drop_h1 |-> pins_h1.col ##1 (pins_h0.col && pins_h1.col))
    else $error("column address not held");
  cas_late_a: assert property (cas_drop_h1 |-> ##1 (!pins_h0.cas_n[0] && !pins_h1.cas_n[0])
    ##1 (t0.col_strobe_width != dbtc_pkg::COL_STROBE_WIDTH_LONG || !pins_h0.cas_n[0])) else $error("column strobe too short");
  stall_len_a: assert property ($fell(bus_stall) |-> slen == {1'b0, t0.rdta})
    else $error("read turnaround length wrong");
  stall_busy_a: assert property (bus_stall |-> !acc_ready) else $error("request accepted in turnaround");
  ack_last_a: assert property (burst_ack && t0.ack == dbtc_pkg::ACK_LAST
    |-> data_ready && data_word == dbtc_pkg::WORD_LAST) else $error("burst ack not with last word");
  wr_early_a: assert property (!t0.wrta && $past(pins_h1.drive) && !pins_h0.drive
    |-> !pins_h0.cas_n[0] && !pins_h1.cas_n[0] ##1 pins_h0.cas_n[0]) else $error("early release wrong");
  wr_late_a: assert property (t0.wrta && $past(pins_h1.drive) && !pins_h0.drive
    |-> pins_h0.cas_n[0] && !$past(pins_h1.cas_n[0])) else $error("bus released before column strobe end");
endmodule
bind dbtc_ctrl dbtc_ctrl_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .acc_valid, .acc_ready, .acc_bank, .acc_page_hit, .pins_h0, .pins_h1, .data_ready, .data_word, .burst_ack,
  .bus_stall);

// >>> dbtc_dram_model.sv
`timescale 1ns/10ps
module dbtc_dram_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire dbtc_pkg::dbtc_pins_s pins_h0,
  input wire dbtc_pkg::dbtc_pins_s pins_h1,
  output logic [7:0] cas_count,
  output logic [3:0] ras_banks
);
  logic [3:0] prev_cas;
  logic [3:0] prev_ras;
  // Counts column strobe assertions, remembers banks opened by the last row strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cas_count <= 8'h00;
      ras_banks <= 4'h0;
      prev_cas <= 4'hF;
      prev_ras <= 4'hF;
    end else begin
      cas_count <= cas_count + 8'(|(prev_cas & ~pins_h0.cas_n)) + 8'(|(pins_h0.cas_n & ~pins_h1.cas_n));
      if (|(prev_ras & ~pins_h0.ras_n)) begin
        ras_banks <= ~pins_h0.ras_n;
      end else if (|(pins_h0.ras_n & ~pins_h1.ras_n)) begin
        ras_banks <= ~pins_h1.ras_n;
      end
      prev_cas <= pins_h1.cas_n;
      prev_ras <= pins_h1.ras_n;
    end
  end
endmodule

// >>> dbtc_bench.sv
`timescale 1ns/10ps
module dbtc_bench;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic err;} dbtc_row_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, acc_valid = 1'b0, acc_write = 1'b0, acc_burst = 1'b0;
  logic acc_page_hit = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] acc_bank = 2'h0, data_word;
  logic [11:0] acc_row = 12'h123, acc_col = 12'h045, dram_addr, ra, ca;
  logic pready, pslverr, acc_ready, data_ready, burst_ack, bus_stall, oe_even_n, oe_odd_n, err, mux_on;
  dbtc_pkg::dbtc_pins_s pins_h0, pins_h1;
  logic [7:0] cas_count, c0;
  logic [3:0] ras_banks;
  int n_fail = 0, total_checks = 0, cyc = 0, nwords, nack, nstall, oe_bad, nodd, tack, ttake, ta;
  int wt[4];
  logic [15:0] tv[8] = '{16'h051F, 16'h451F, 16'h151F, 16'h251F, 16'h091F, 16'h041F, 16'h071F, 16'h551F};
  logic [7:0] cf[4] = '{8'h00, 8'h20, 8'h10, 8'h30};
  logic [7:0] nc[4] = '{8'h02, 8'h04, 8'h08, 8'h08};
  dbtc_row_s rows[10] = '{
    {1'b0, 8'h00, 32'h0, 32'h051F, 1'b0}, {1'b0, 8'h10, 32'h0, 32'h0000, 1'b0},
    {1'b1, 8'h00, 32'hFFFFFFFF, 32'h0, 1'b0}, {1'b0, 8'h00, 32'h0, 32'hFF5F, 1'b0},
    {1'b1, 8'h00, 32'h051F, 32'h0, 1'b0}, {1'b1, 8'h14, 32'hFF, 32'h0, 1'b0},
    {1'b0, 8'h14, 32'h0, 32'h00F8, 1'b0}, {1'b1, 8'h14, 32'h0, 32'h0, 1'b0},
    {1'b0, 8'h30, 32'h0, 32'h0, 1'b1}, {1'b1, 8'h30, 32'hFFFF, 32'h0, 1'b1}};
  dbtc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_valid(acc_valid), .acc_ready(acc_ready), .acc_bank(acc_bank), .acc_write(acc_write),
    .acc_burst(acc_burst), .acc_page_hit(acc_page_hit), .acc_row(acc_row), .acc_col(acc_col),
    .pins_h0(pins_h0), .pins_h1(pins_h1), .dram_addr(dram_addr), .data_ready(data_ready),
    .data_word(data_word), .burst_ack(burst_ack), .bus_stall(bus_stall),
    .even_read_output_enable_n(oe_even_n), .odd_read_output_enable_n(oe_odd_n));
  dbtc_dram_model dram (.pclk(pclk), .presetn(presetn), .pins_h0(pins_h0), .pins_h1(pins_h1),
    .cas_count(cas_count), .ras_banks(ras_banks));
  initial begin
    forever #20 pclk = ~pclk;
  end
  task automatic summarize();
    if (n_fail == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic acc(input logic [1:0] b, input logic w, input logic bu, input logic hit);
    @(posedge pclk);
    while (acc_ready !== 1'b1) @(posedge pclk);
    acc_valid <= 1'b1;
    acc_bank <= b;
    acc_write <= w;
    acc_burst <= bu;
    acc_page_hit <= hit;
    @(posedge pclk);
    ttake = cyc;
    acc_valid <= 1'b0;
    @(posedge pclk);
    while (acc_ready !== 1'b1 || bus_stall !== 1'b0) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  // Per-clock observation of returned words, acknowledge, stall and read enables
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      summarize();
    end
    if (data_ready === 1'b1) begin
      wt[data_word] = cyc;
      nwords++;
    end
    if (burst_ack === 1'b1) begin
      nack++;
      tack = cyc - ttake;
    end
    if (bus_stall === 1'b1) nstall++;
    if (pins_h0.ras_n[0] === 1'b1 && pins_h1.ras_n[0] === 1'b0) ra = dram_addr;
    if (pins_h0.cas_n[0] === 1'b1 && pins_h1.cas_n[0] === 1'b0) ca = dram_addr;
    if (mux_on === 1'b1 && oe_odd_n === 1'b0 && oe_even_n !== 1'b0) oe_bad++;
    if (mux_on === 1'b1 && oe_odd_n === 1'b0) nodd++;
  end
  initial begin
    mux_on = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("pslverr", {31'h0, rows[i].err}, {31'h0, err});
      chk("pready", 32'h1, {31'h0, pready});
      if (!rows[i].w) chk("prdata", rows[i].e, rd);
    end
    foreach (tv[i]) begin
      apb(1'b1, dbtc_pkg::OFF_TIMING, {16'h0, tv[i]});
      nstall = 0;
      nwords = 0;
      acc(2'h0, 1'b0, 1'b0, 1'b0);
      acc(2'h0, 1'b0, 1'b0, 1'b1);
      chk("stall", 32'(tv[i][9:8]) * 32'h2, 32'(nstall));
      chk("words", 32'h2, 32'(nwords));
    end
    apb(1'b1, dbtc_pkg::OFF_TIMING, 32'h051F);
    foreach (cf[i]) begin
      apb(1'b1, dbtc_pkg::OFF_CONFIG, {24'h0, cf[i]});
      c0 = cas_count;
      nwords = 0;
      nack = 0;
      acc(2'h0, 1'b0, 1'b1, 1'b0);
      chk("cas count", {24'h0, nc[i]}, {24'h0, 8'(cas_count - c0)});
      chk("acks", 32'h1, 32'(nack));
      chk("row address", 32'h123, {20'h0, ra});
      if (i < 2) chk("column address", i == 0 ? 32'h047 : 32'h048, {20'h0, ca});
      if (i < 2) chk("words", 32'h4, 32'(nwords));
      if (i == 0) chk("word gap", 32'h00010001, {16'(wt[1] - wt[0]), 16'(wt[3] - wt[2])});
    end
    apb(1'b1, dbtc_pkg::OFF_CONFIG, 32'h0);
    apb(1'b1, dbtc_pkg::OFF_TIMING, 32'h0500);
    acc(2'h0, 1'b0, 1'b1, 1'b0);
    ta = tack;
    apb(1'b1, dbtc_pkg::OFF_TIMING, 32'h0502);
    acc(2'h0, 1'b0, 1'b1, 1'b0);
    chk("ack shift", 32'h2, 32'(tack - ta));
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, dbtc_pkg::OFF_TIMING, 32'h051F);
      apb(1'b1, dbtc_pkg::OFF_TIMING + 8'h04, 32'h051F);
      apb(1'b1, dbtc_pkg::OFF_CONFIG, i == 0 ? 32'h58 : 32'h40);
      apb(1'b1, dbtc_pkg::OFF_CONFIG + 8'h04, i == 0 ? 32'h58 : 32'h40);
      mux_on = 1'b1;
      oe_bad = 0;
      nodd = 0;
      nwords = 0;
      acc(2'h0, 1'b0, 1'b1, 1'b0);
      mux_on = 1'b0;
      chk("ras banks", i == 0 ? 32'h3 : 32'h1, {28'h0, ras_banks});
      chk("even enable", 32'h0, 32'(oe_bad));
      chk("odd enable", i == 0 ? 32'h1 : 32'h0, {31'h0, nodd != 0});
      chk("words", 32'h4, 32'(nwords));
      if (i == 1) chk("word gap", 32'h00010001, {16'(wt[1] - wt[0]), 16'(wt[3] - wt[2])});
    end
    apb(1'b1, dbtc_pkg::OFF_CONFIG, 32'h0);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, dbtc_pkg::OFF_TIMING, i == 0 ? 32'h051F : 32'h055F);
      nwords = 0;
      nstall = 0;
      acc(2'h0, 1'b1, 1'b0, 1'b0);
      acc(2'h0, 1'b1, 1'b1, 1'b1);
      chk("write words", 32'h0, 32'(nwords + nstall));
    end
    apb(1'b1, dbtc_pkg::OFF_TIMING, 32'h451F);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_page_hit <= 1'b0;
    @(posedge pclk);
    acc_valid <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("ready after reset", 32'h1, {31'h0, acc_ready});
    apb(1'b0, dbtc_pkg::OFF_TIMING, 32'h0);
    chk("timing after reset", {16'h0, dbtc_pkg::TIMING_RESET}, rd);
    acc(2'h0, 1'b0, 1'b0, 1'b0);
    summarize();
  end
endmodule
